// ===== flsc_top.sv
`timescale 1ns/1ns
`include "flsc_map.svh"
// Functional notes
// - secured boots internal from 0x020000, no p-space
// - secured ignores external boot select pin
// - tap active at boot, idcode and scan
// - secured denies debug memory access over jtag
// - debug read disable set from security bytes
// - recovery erases whole flash, security stays in force until the next reset
// - recovery instruction selects 7-bit divider register
// - jtag divider overrides flash timing ratio register
// - bit6 prescale by eight, bits5-0 ratio
// - erase starts in run-test/idle, host waits there
// - backdoor unsecure only with key enable set
// - secured state kept across resets from flash
module flsc_top
  import flsc_pkg::*;
#(
  parameter logic [31:0] IDCODE = 32'h00000001 // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // flash security bytes and backdoor key
  input wire logic [15:0] sec_bytes_i,
  input wire logic [15:0] key_word_i,
  input wire logic external_boot_select_i,
  // boot and access control toward the core
  output flsc_boot_t boot_o,
  input wire logic xp_req_i,
  output logic xp_grant_o,
  input wire logic dbg_mem_req_i,
  output logic dbg_mem_grant_o,
  output logic dbg_rd_dis_o,
  // jtag pins and boundary chain
  input flsc_jtag_t jtag_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic bsr_sel_o,
  input wire logic bsr_tdo_i,
  // flash erase and timing
  output logic erase_req_o,
  input wire logic erase_done_i,
  output logic flash_tick_o
);
  // security decode of the stored bytes
  function automatic logic sec_open(input logic [15:0] b);
    sec_open = (b[`FLSC_SEC_LSB+:2] == `FLSC_SEC_OPEN);
  endfunction : sec_open

  // tap next state from tms
  function automatic flsc_tap_t tap_next(input flsc_tap_t s,
                                         input logic m);
    case (s)
      TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  logic booted; // high from the first cycle after reset
  logic secured; // security latched from flash bytes
  logic key_en; // backdoor key enable latched
  logic unlocked; // backdoor key matched
  logic sec_eff; // security in force now
  logic open_now; // live decode of the bytes
  logic [6:0] ratio; // software flash timing ratio
  logic tck_q; // previous tck sample
  logic tck_rise; // tck rising this cycle
  logic tck_fall; // tck falling this cycle
  flsc_tap_t st; // tap state
  logic [3:0] ir; // active instruction
  logic [3:0] ir_sh; // instruction shifter
  logic [31:0] dr_sh; // data shifter
  logic [6:0] rec_div; // recovery clock setting
  logic armed; // recovery divider loaded
  logic erased; // erase finished
  logic dr_bit; // data register output bit
  logic half; // system clock over two
  logic [2:0] pre_cnt; // prescale counter
  logic [5:0] div_cnt; // ratio counter
  logic flash_prescale_by_eight; // prescale by eight in force
  logic [5:0] div; // ratio in force
  logic pre_tick; // prescaled enable
  logic [31:0] status; // status word

  assign open_now = sec_open(sec_bytes_i);
  assign sec_eff = secured & ~unlocked;

  // latch security and boot mode at the first cycle after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      booted <= 1'b0;
      secured <= 1'b1;
      key_en <= 1'b0;
      boot_o <= {1'b1, 1'b0, `FLSC_BOOT_INT};
    end else if (!booted) begin
      booted <= 1'b1;
      secured <= ~open_now;
      key_en <= sec_bytes_i[`FLSC_BACKDOOR_KEY_ENABLE_BIT];
      if (external_boot_select_i && open_now) begin
        boot_o <= {1'b0, 1'b1, `FLSC_BOOT_EXT};
      end else begin
        boot_o <= {1'b1, 1'b0, `FLSC_BOOT_INT};
      end
    end
  end

  // access gates toward the core
  assign xp_grant_o = xp_req_i & ~sec_eff;
  assign dbg_mem_grant_o = dbg_mem_req_i & ~sec_eff;
  assign dbg_rd_dis_o = sec_eff;

  // wishbone ack, one cycle after the request, dropped after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end

  // register writes: ratio and backdoor key
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio <= `FLSC_RATIO_RST;
      unlocked <= 1'b0;
    end else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0]) begin
      if (adr_i == `FLSC_REG_RATIO) begin
        ratio <= dat_i[6:0];
      end else if (adr_i == `FLSC_REG_KEY && sel_i[1]) begin
        if (key_en && dat_i[15:0] == key_word_i) begin
          unlocked <= 1'b1;
        end
      end
    end
  end

  // status word
  always_comb begin
    status = 32'h00000000;
    status[`FLSC_ST_SECURED] = sec_eff;
    status[`FLSC_ST_EXTERNAL_BOOT_SELECT] = boot_o.ext;
    status[`FLSC_ST_ARMED] = armed;
    status[`FLSC_ST_ERASING] = erase_req_o;
    status[`FLSC_ST_ERASED] = erased;
    status[`FLSC_ST_BACKDOOR_KEY_ENABLE] = key_en;
  end

  // read data, zero for unmapped offsets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      if (adr_i == `FLSC_REG_RATIO) begin
        dat_o <= {25'h0000000, ratio};
      end else if (adr_i == `FLSC_REG_STATUS) begin
        dat_o <= status;
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

  // tck edge detection on the synchronous pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= jtag_i.tck;
    end
  end
  assign tck_rise = jtag_i.tck & ~tck_q;
  assign tck_fall = ~jtag_i.tck & tck_q;

  // tap state, active from boot whatever security says
  always_ff @(posedge clk_i) begin
    if (rst_i || !jtag_i.trst_n) begin
      st <= TAP_RESET;
    end else if (tck_rise) begin
      st <= tap_next(st, jtag_i.tms);
    end
  end

  // instruction register, idcode after tap reset
  always_ff @(posedge clk_i) begin
    if (rst_i || !jtag_i.trst_n) begin
      ir <= `FLSC_IR_IDCODE;
      ir_sh <= 4'h0;
    end else if (tck_rise) begin
      if (st == TAP_RESET) begin
        ir <= `FLSC_IR_IDCODE;
      end else if (st == TAP_CAP_IR) begin
        ir_sh <= 4'h1;
      end else if (st == TAP_SH_IR) begin
        ir_sh <= {jtag_i.tdi, ir_sh[3:1]};
      end else if (st == TAP_UPD_IR) begin
        ir <= ir_sh;
      end
    end
  end

  // data registers: idcode, recovery divider, bypass
  always_ff @(posedge clk_i) begin
    if (rst_i || !jtag_i.trst_n) begin
      dr_sh <= 32'h00000000;
    end else if (tck_rise) begin
      if (st == TAP_CAP_DR) begin
        if (ir == `FLSC_IR_IDCODE) begin
          dr_sh <= IDCODE;
        end else if (ir == `FLSC_IR_RECOVER) begin
          dr_sh <= {25'h0000000, rec_div};
        end else begin
          dr_sh <= 32'h00000000;
        end
      end else if (st == TAP_SH_DR) begin
        if (ir == `FLSC_IR_IDCODE) begin
          dr_sh <= {jtag_i.tdi, dr_sh[31:1]};
        end else if (ir == `FLSC_IR_RECOVER) begin
          dr_sh[6:0] <= {jtag_i.tdi, dr_sh[6:1]};
        end else begin
          dr_sh[0] <= jtag_i.tdi;
        end
      end
    end
  end

  // recovery divider load and erase sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i || !jtag_i.trst_n) begin
      rec_div <= 7'h00;
      armed <= 1'b0;
      erase_req_o <= 1'b0;
      erased <= 1'b0;
    end else begin
      if (tck_rise && st == TAP_UPD_DR && ir == `FLSC_IR_RECOVER) begin
        rec_div <= dr_sh[6:0];
        armed <= 1'b1;
      end
      if (erase_req_o && erase_done_i) begin
        erase_req_o <= 1'b0;
        erased <= 1'b1;
      end else if (st != TAP_IDLE) begin
        erase_req_o <= 1'b0; // leaving idle aborts
      end else if (armed && !erased) begin
        erase_req_o <= 1'b1;
      end
    end
  end

  // tdo changes on tck falling, driven in shift states only
  assign bsr_sel_o = (ir == `FLSC_IR_EXTEST);
  assign dr_bit = bsr_sel_o ? bsr_tdo_i : dr_sh[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= (st == TAP_SH_IR) ? ir_sh[0] : dr_bit;
      tdo_oe_o <= (st == TAP_SH_IR) || (st == TAP_SH_DR);
    end
  end

  // divider selection: jtag value replaces the ratio register
  assign flash_prescale_by_eight = armed ? rec_div[`FLSC_FLASH_PRESCALE_BY_EIGHT_BIT] : ratio[6];
  assign div = armed ? rec_div[5:0] : ratio[5:0];
  assign pre_tick = half & (~flash_prescale_by_eight | (pre_cnt == 3'h7));

  // flash timing clock: clk/2, optional /8, then /(div+1)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half <= 1'b0;
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
      flash_tick_o <= 1'b0;
    end else begin
      half <= ~half;
      flash_tick_o <= 1'b0;
      if (half) begin
        pre_cnt <= pre_cnt + 3'h1;
      end
      if (pre_tick) begin
        if (div_cnt >= div) begin
          div_cnt <= 6'h00;
          flash_tick_o <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 6'h01;
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_secure_boot: assert property (
    booted && secured |-> boot_o.internal && !boot_o.ext
      && boot_o.addr == `FLSC_BOOT_INT && !xp_grant_o || unlocked)
    else $error("secured part did not boot internal");
  chk_ext_ignored: assert property (
    $rose(booted) && !$past(open_now) |-> !boot_o.ext)
    else $error("external boot taken while secured");
  chk_ext_honoured: assert property (
    $rose(booted) |-> boot_o.ext ==
      ($past(external_boot_select_i) && $past(open_now)))
    else $error("external boot select not honoured");
  chk_debug_denied: assert property (
    sec_eff && dbg_mem_req_i |-> !dbg_mem_grant_o)
    else $error("debug memory access while secured");
  chk_debug_disable: assert property (
    $rose(booted) |-> dbg_rd_dis_o == !$past(open_now))
    else $error("debug read disable wrong after reset");
  chk_idcode_capture: assert property (
    tck_rise && st == TAP_CAP_DR && ir == `FLSC_IR_IDCODE
      && jtag_i.trst_n |=> dr_sh == IDCODE)
    else $error("idcode not captured");
  chk_divider_load: assert property (
    tck_rise && st == TAP_UPD_DR && ir == `FLSC_IR_RECOVER
      && jtag_i.trst_n |=> armed && rec_div == $past(dr_sh[6:0]))
    else $error("recovery divider not loaded");
  chk_divider_override: assert property (
    armed |-> flash_prescale_by_eight == rec_div[6] && div == rec_div[5:0])
    else $error("recovery divider not in force");
  chk_erase_start: assert property (
    armed && !erased && st == TAP_IDLE && !tck_rise
      && jtag_i.trst_n && !erase_req_o |=> erase_req_o)
    else $error("erase did not start in idle");
  chk_key_gate: assert property (
    !key_en |-> !unlocked)
    else $error("backdoor unlock without key enable");
endmodule : flsc_top

// ===== flsc_map.svh
`ifndef FLSC_MAP_SVH
`define FLSC_MAP_SVH
// register byte offsets on the wishbone slave
`define FLSC_REG_RATIO 4'h0
`define FLSC_REG_STATUS 4'h4
`define FLSC_REG_KEY 4'h8
// reset value of the software timing ratio register
`define FLSC_RATIO_RST 7'h00
// status register bit positions
`define FLSC_ST_SECURED 0
`define FLSC_ST_EXTERNAL_BOOT_SELECT 1
`define FLSC_ST_ARMED 2
`define FLSC_ST_ERASING 3
`define FLSC_ST_ERASED 4
`define FLSC_ST_BACKDOOR_KEY_ENABLE 5
// security byte field layout and the pattern that means open
`define FLSC_SEC_LSB 0
`define FLSC_SEC_OPEN 2'h2
`define FLSC_BACKDOOR_KEY_ENABLE_BIT 15
// boot fetch addresses
`define FLSC_BOOT_INT 24'h020000
`define FLSC_BOOT_EXT 24'h000000
// divider field positions
`define FLSC_FLASH_PRESCALE_BY_EIGHT_BIT 6
// tap instruction codes
`define FLSC_IR_EXTEST 4'h0
`define FLSC_IR_IDCODE 4'h2
`define FLSC_IR_RECOVER 4'h7
`define FLSC_IR_BYPASS 4'hF
`endif

// ===== flsc_pkg.sv
package flsc_pkg;
  // tap controller states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PA_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } flsc_tap_t;
  // jtag pins as seen by the device
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } flsc_jtag_t;
  // boot decision handed to the core
  typedef struct packed {
    logic internal;
    logic ext;
    logic [23:0] addr;
  } flsc_boot_t;
endpackage : flsc_pkg

// ===== flsc_jtag_host.sv
`timescale 1ns/1ns
// jtag host model: slow tck made from the system clock, lsb first shifts
module flsc_jtag_host
  import flsc_pkg::*;
(
  // clock and returned data
  input wire logic clk_i,
  input wire logic tdo_i,
  // pins toward the device
  output flsc_jtag_t jtag_o
);
  // tck rests low between frames
  initial begin
    jtag_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
  end
  // one tck period: low phase sets tms/tdi, tdo taken just before the rise
  task automatic step(input logic tms, input logic sh, input logic d,
                      output logic q);
    @(posedge clk_i);
    jtag_o.tms <= tms;
    jtag_o.tdi <= sh ? d : ~jtag_o.tdi; // unused data never holds still
    repeat (3) @(posedge clk_i);
    q = tdo_i;
    jtag_o.tck <= 1'b1;
    repeat (3) @(posedge clk_i);
    jtag_o.tck <= 1'b0;
  endtask : step
  // one step back into run-test/idle
  task automatic idle();
    logic q;
    step(1'b0, 1'b0, 1'b0, q);
  endtask : idle
  // test reset pin pulse, then park in run-test/idle
  task automatic trst();
    @(posedge clk_i);
    jtag_o.trst_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    jtag_o.trst_n <= 1'b1;
    idle();
  endtask : trst
  // idle to shift, n bits, stop in update
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, 1'b0, q);
    if (ir) begin
      step(1'b1, 1'b0, 1'b0, q);
    end
    step(1'b0, 1'b0, 1'b0, q);
    step(1'b0, 1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, 1'b1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, 1'b0, q);
  endtask : shift
endmodule : flsc_jtag_host

// ===== flsc_top_bench.sv
`timescale 1ns/1ns
`include "flsc_map.svh"
// bench: reads queue their expected data, a watcher compares on ack
module flsc_top_bench;
  import flsc_pkg::*;
  localparam logic [31:0] ID = 32'h00000B01; // arbitrary value
  // design inputs with their time-zero values
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic [15:0] sec_bytes_i = 16'h0;
  logic [15:0] key_word_i = 16'h0;
  logic external_boot_select_i = 1'b0;
  logic xp_req_i = 1'b1;
  logic dbg_mem_req_i = 1'b1;
  logic erase_done_i = 1'b0;
  // design outputs
  logic [31:0] dat_o;
  logic ack_o, xp_grant_o, dbg_mem_grant_o, dbg_rd_dis_o;
  logic tdo_o, tdo_oe_o, bsr_sel_o, erase_req_o, flash_tick_o;
  flsc_boot_t boot_o;
  flsc_jtag_t jtag_i;
  // bookkeeping
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic oe_seen = 1'b0; // tdo driver seen enabled at least once
  logic [31:0] exp_q[$];
  logic [31:0] d;
  logic [15:0] k;
  logic [6:0] r;
  // free running system clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  flsc_top #(.IDCODE(ID)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sec_bytes_i, .key_word_i,
    .external_boot_select_i, .boot_o, .xp_req_i, .xp_grant_o,
    .dbg_mem_req_i, .dbg_mem_grant_o, .dbg_rd_dis_o, .jtag_i, .tdo_o,
    .tdo_oe_o, .bsr_sel_o, .bsr_tdo_i(1'b0), .erase_req_o, .erase_done_i,
    .flash_tick_o);
  flsc_jtag_host host (.clk_i, .tdo_i(tdo_o), .jtag_o(jtag_i));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic test_done();
    $display("checked %0d, failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails++;
      test_done();
    end
  end
  // read data watcher takes the oldest note on each read ack
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      check(dat_o, exp_q.pop_front());
    end
  end
  // remembers that the tdo driver was enabled during a shift
  always @(posedge clk_i) begin
    if (tdo_oe_o === 1'b1) begin
      oe_seen <= 1'b1;
    end
  end
  // classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= v;
    @(posedge clk_i);
    // only the hang guard ends a wait that never sees ack
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // read with its expected value noted first
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  // device reset with given stored bytes and boot pin
  task automatic dev_reset(input logic [15:0] sec, input logic ext);
    @(posedge clk_i);
    rst_i <= 1'b1;
    sec_bytes_i <= sec;
    external_boot_select_i <= ext;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : dev_reset
  // boot, gating and status after a reset
  task automatic access(input logic open, input logic ext,
                        input logic [31:0] st);
    // random requests toward the gates, settled one edge later
    @(posedge clk_i);
    xp_req_i <= 1'($urandom);
    dbg_mem_req_i <= 1'($urandom);
    @(posedge clk_i);
    check({boot_o.internal, boot_o.ext}, {30'h0, ~ext, ext});
    check(boot_o.addr, ext ? `FLSC_BOOT_EXT : `FLSC_BOOT_INT);
    check({xp_grant_o, dbg_mem_grant_o},
          {30'h0, xp_req_i & open, dbg_mem_req_i & open});
    check(dbg_rd_dis_o, {31'h0, !open});
    rd(`FLSC_REG_STATUS, st);
  endtask : access
  // spacing of two flash timing pulses
  task automatic tick_gap(input int e);
    int n;
    n = 0;
    @(posedge clk_i iff flash_tick_o === 1'b1);
    do begin
      @(posedge clk_i);
      n++;
    end while (flash_tick_o !== 1'b1 && n < 3000);
    check(n, e);
  endtask : tick_gap
  // main sequence
  initial begin
    void'($urandom(11));
    k = 16'($urandom);
    key_word_i <= k; // key stored before the security bytes
    dev_reset(16'h0000, 1'b1);
    access(1'b0, 1'b0, 32'h1);
    rd(`FLSC_REG_RATIO, 32'h0);
    rd(4'hC, 32'h0);
    tick_gap(2);
    repeat (3) begin
      r = 7'($urandom);
      wb(1'b1, `FLSC_REG_RATIO, {25'h0, r});
      rd(`FLSC_REG_RATIO, {25'h0, r});
      tick_gap(2 * (r[6] ? 8 : 1) * (r[5:0] + 1));
    end
    dev_reset(16'h8000, 1'b0);
    access(1'b0, 1'b0, 32'h21);
    wb(1'b1, `FLSC_REG_KEY, {16'h0, ~k});
    access(1'b0, 1'b0, 32'h21);
    wb(1'b1, `FLSC_REG_KEY, {16'h0, k});
    access(1'b1, 1'b0, 32'h20);
    dev_reset(16'h0000, 1'b0);
    wb(1'b1, `FLSC_REG_KEY, {16'h0, k});
    access(1'b0, 1'b0, 32'h1);
    dev_reset(16'h0002, 1'b1);
    access(1'b1, 1'b1, 32'h2);
    dev_reset(16'h0000, 1'b0);
    host.trst();
    host.shift(1'b0, 32, 32'h0, d);
    check(d, ID);
    check(oe_seen, 1'b1);
    check(tdo_oe_o, 1'b0);
    host.shift(1'b1, 4, {28'h0, `FLSC_IR_EXTEST}, d);
    host.idle();
    check(bsr_sel_o, 1'b1);
    host.shift(1'b1, 4, {28'h0, `FLSC_IR_RECOVER}, d);
    host.idle();
    host.shift(1'b0, 7, 32'h4F, d);
    check(erase_req_o, 1'b0);
    host.idle();
    check(erase_req_o, 1'b1);
    tick_gap(256);
    @(posedge clk_i);
    erase_done_i <= 1'b1;
    @(posedge clk_i);
    erase_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(erase_req_o, 1'b0);
    rd(`FLSC_REG_STATUS, 32'h15);
    host.trst();
    dev_reset(16'h0002, 1'b0);
    access(1'b1, 1'b0, 32'h0);
    repeat (4) @(posedge clk_i);
    check(exp_q.size(), 0);
    test_done();
  end
endmodule : flsc_top_bench
